// ===== pkg/dnc_pkg.sv
// constants for the oscillator control register bank
// assumes a byte-wide write-only port with a 4-bit address
package dnc_pkg;

  // ***************************************************************
  // port and register geometry
  // ***************************************************************
  localparam int          DATA_W     = 8;
  localparam int          ADDR_W     = 4;
  localparam int          NUM_REGS   = 15;  // addresses 0..14 store data
  localparam int          FREQ_W     = 48;
  localparam int          SER_W      = 40;

  // ***************************************************************
  // register offsets
  // ***************************************************************
  localparam logic [3:0]  OFS_CF0    = 4'h0;   // centre word, low byte
  localparam logic [3:0]  OFS_CF5    = 4'h5;   // centre word, high byte
  localparam logic [3:0]  OFS_OF0    = 4'h6;   // offset word, low byte
  localparam logic [3:0]  OFS_SER    = 4'hc;   // serial input control
  localparam logic [3:0]  OFS_OSC    = 4'hd;   // oscillator control
  localparam logic [3:0]  OFS_TT     = 4'he;   // test and timing
  localparam logic [3:0]  OFS_COMMIT = 4'hf;   // no storage, commit

  // ***************************************************************
  // reset values
  // ***************************************************************
  localparam logic [7:0]  RST_ZERO   = 8'h00;
  localparam logic [7:0]  RST_CF5    = 8'h40;  // centre word = 1/4 rate
  localparam logic [7:0]  RST_SER    = 8'h01;
  localparam logic [7:0]  RST_OSC    = 8'hf8;
  localparam logic [7:0]  RST_TT     = 8'h10;

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int          SER_LEN_HI   = 7;
  localparam int          SER_LEN_LO   = 5;
  localparam int          SER_SYNC_EARLY = 4;
  localparam int          SER_SYNC_LOW = 3;
  localparam int          SER_CLK_FALL = 2;
  localparam int          SER_LSB_FIRST = 1;
  localparam int          SER_CF_EN    = 0;
  localparam int          OSC_RSVD_HI  = 7;
  localparam int          OSC_SER_EN   = 6;
  localparam int          OSC_FB_EN    = 5;
  localparam int          OSC_RSVD_LO_HI = 4;
  localparam logic [4:0]  OSC_RSVD_LO_RST = 5'b1_1000;
  localparam int          TT_TIM_HI    = 5;
  localparam int          TT_TIM_LO    = 4;

  // ***************************************************************
  // serial word length codes
  // ***************************************************************
  localparam logic [2:0]  LEN_32     = 3'h3;
  localparam logic [2:0]  LEN_24     = 3'h2;
  localparam logic [2:0]  LEN_16     = 3'h1;
  localparam logic [2:0]  LEN_8      = 3'h0;

  // reset value of one stored byte address
  function automatic logic [7:0] reg_reset(input int idx);
    case (idx)
      5:       return RST_CF5;
      12:      return RST_SER;
      13:      return RST_OSC;
      14:      return RST_TT;
      default: return RST_ZERO;
    endcase
  endfunction : reg_reset

endpackage : dnc_pkg

// ===== hw/dnc_hold_reg.sv
// one holding register and its active copy
// assumes writes and commit are qualified one-cycle levels on clk
`timescale 1ns/1ps
module dnc_hold_reg
#(
  parameter int         WIDTH = 8,
  parameter logic [7:0] RESET = 8'h00
)
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             commit,
  output logic      [WIDTH-1:0] hold_q,
  output logic      [WIDTH-1:0] active_q
);

  // the reset value parameter is one byte wide, so wider is refused
  if (WIDTH < 1 || WIDTH > 8)
  begin : g_bad_width
    $error("dnc_hold_reg: WIDTH must be 1 to 8");
  end

  logic [WIDTH-1:0] hold_r;
  logic [WIDTH-1:0] active_r;

  // ***************************************************************
  // holding side takes the host byte, active side takes the commit
  // ***************************************************************
  // commit copies the old holding byte, so a same-cycle write waits
  // for the next commit rather than racing through
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hold_r   <= RESET[WIDTH-1:0];
      active_r <= RESET[WIDTH-1:0];
    end
    else if (ce)
    begin
      if (wr_en)
        hold_r <= wr_data;
      if (commit)
        active_r <= hold_r;
    end
  end

  assign hold_q   = hold_r;
  assign active_q = active_r;

endmodule : dnc_hold_reg

// ===== hw/dnc_ctrl.sv
// control register bank and phase accumulator feed of the oscillator
// assumes the host port pins are synchronous to clk and that the
// serial receiver delivers its word right-justified on ser_word
//
// Behaviour
// - shift-order bit clear means MSB first, set LSB first; resets clear.
// - centre enable clear zeros centre word into accumulator; resets set.
// - disabling centre path leaves the stored centre word untouched.
// - after reset the centre word yields output at one quarter clock.
// - oscillator control resets F8h; reserved bits kept as written.
// - bit 6 gates serial word into accumulator, storage untouched; resets set.
// - bit 5 clear stops accumulator feedback; set accumulates; resets set.
// - test bits 5:4 pick converter timing, reset 01b, host writes 11b/00b.
// - a write to address 15 commits exactly like the commit pin.
// - serial length code aligns the word to the top of the centre word.
`timescale 1ns/1ps
module dnc_ctrl
#(
  parameter int FREQ_W = dnc_pkg::FREQ_W,
  parameter int SER_W  = dnc_pkg::SER_W
)
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  // host parallel port, write only
  input  wire logic              wr_strobe,
  input  wire logic              wr_en_n,
  input  wire logic [3:0]        addr,
  input  wire logic [7:0]        wdata,
  input  wire logic              commit_n,
  // frequency inputs from neighbouring logic
  input  wire logic [SER_W-1:0]  ser_word,
  input  wire logic              offset_path_en,
  // serial receiver configuration
  output logic [2:0]             ser_len_code,
  output logic                   ser_sync_early,
  output logic                   ser_sync_act_low,
  output logic                   ser_clk_fall,
  output logic                   ser_lsb_first,
  // converter timing
  output logic [1:0]             dac_timing_sel,
  // data path view
  output logic [FREQ_W-1:0]      centre_freq_word,
  output logic [FREQ_W-1:0]      freq_sum,
  output logic [FREQ_W-1:0]      phase_acc,
  output logic                   commit_seen
);

  // ***************************************************************
  // elaboration checks
  // ***************************************************************
  // the byte map is fixed at six bytes per frequency word
  if (FREQ_W != 48)
  begin : g_bad_freq
    $error("dnc_ctrl: FREQ_W must be 48");
  end
  if (SER_W != 40)
  begin : g_bad_ser
    $error("dnc_ctrl: SER_W must be 40");
  end

  // ***************************************************************
  // host port decode
  // ***************************************************************
  logic        wr_take;
  logic        wr_commit_addr;
  logic        commit_pin;
  logic        commit_now;
  logic [14:0] wr_sel;

  // a write is a strobe cycle with the enable low
  assign wr_take        = wr_strobe & ~wr_en_n;
  // the top address has no storage and only commits, data ignored
  assign wr_commit_addr = wr_take & (addr == dnc_pkg::OFS_COMMIT);
  assign commit_pin     = ~commit_n;
  // either source gives the very same action
  assign commit_now     = commit_pin | wr_commit_addr;

  // one-hot byte select for the stored addresses
  genvar gi;
  generate
    for (gi = 0; gi < dnc_pkg::NUM_REGS; gi++)
    begin : g_sel
      assign wr_sel[gi] = wr_take & (addr == 4'(gi));
    end
  endgenerate

  // ***************************************************************
  // holding and active registers
  // ***************************************************************
  logic [7:0] hold_b   [0:14];
  logic [7:0] active_b [0:14];

  // each stored byte is a holding/active pair; all pairs share one
  // commit so the data path sees a whole new set in a single cycle
  generate
    for (gi = 0; gi < dnc_pkg::NUM_REGS; gi++)
    begin : g_reg
      dnc_hold_reg
      #(
        .WIDTH (8),
        .RESET (dnc_pkg::reg_reset(gi))
      )
      u_reg
      (
        .clk      (clk),
        .rst      (rst),
        .ce       (ce),
        .wr_en    (wr_sel[gi]),
        .wr_data  (wdata),
        .commit   (commit_now),
        .hold_q   (hold_b[gi]),
        .active_q (active_b[gi])
      );
    end
  endgenerate

  // ***************************************************************
  // active word assembly
  // ***************************************************************
  logic [FREQ_W-1:0] cf_word;
  logic [FREQ_W-1:0] of_word;
  logic [7:0]        ser_ctl;
  logic [7:0]        osc_ctl;
  logic [7:0]        tt_ctl;
  logic [4:0]        osc_rsvd_lo;
  logic              osc_rsvd_hi;

  // byte 5 resets to 40h, so the word is 2^46: a quarter turn per clock
  assign cf_word = {active_b[5], active_b[4], active_b[3],
                    active_b[2], active_b[1], active_b[0]};
  assign of_word = {active_b[11], active_b[10], active_b[9],
                    active_b[8],  active_b[7],  active_b[6]};
  assign ser_ctl = active_b[12];
  assign osc_ctl = active_b[13];
  assign tt_ctl  = active_b[14];

  // reserved fields are stored as written and drive nothing; reset
  // gives F8h and the host is expected to write them back unchanged
  assign osc_rsvd_hi = osc_ctl[dnc_pkg::OSC_RSVD_HI];
  assign osc_rsvd_lo = osc_ctl[dnc_pkg::OSC_RSVD_LO_HI:0];

  // ***************************************************************
  // control fields
  // ***************************************************************
  logic       cf_en;
  logic       ser_en;
  logic       fb_en;
  logic [2:0] len_code;

  assign cf_en    = ser_ctl[dnc_pkg::SER_CF_EN];
  assign ser_en   = osc_ctl[dnc_pkg::OSC_SER_EN];
  assign fb_en    = osc_ctl[dnc_pkg::OSC_FB_EN];
  assign len_code = ser_ctl[dnc_pkg::SER_LEN_HI:dnc_pkg::SER_LEN_LO];

  // ***************************************************************
  // serial word alignment
  // ***************************************************************
  logic [FREQ_W-1:0] ser_aligned;

  // the received bits always land on the top of the centre weighting;
  // any code with the top bit set takes the full 40 bits
  always_comb
  begin
    ser_aligned = '0;
    if (len_code[2])
      ser_aligned = {ser_word[39:0], 8'h00};
    else
    begin
      case (len_code)
        dnc_pkg::LEN_32: ser_aligned = {ser_word[31:0], 16'h0000};
        dnc_pkg::LEN_24: ser_aligned = {ser_word[23:0], 24'h00_0000};
        dnc_pkg::LEN_16: ser_aligned = {ser_word[15:0], 32'h0000_0000};
        dnc_pkg::LEN_8:  ser_aligned = {ser_word[7:0], 40'h00_0000_0000};
        default:         ser_aligned = '0;
      endcase
    end
  end

  // ***************************************************************
  // gated paths into the accumulator
  // ***************************************************************
  logic [FREQ_W-1:0] cf_path;
  logic [FREQ_W-1:0] ser_path;
  logic [FREQ_W-1:0] of_path;
  logic [FREQ_W-1:0] sum_nxt;

  // gating sits after the registers, so a disabled path keeps its
  // stored word and comes back unchanged once re-enabled
  assign cf_path  = cf_en ? cf_word : '0;
  assign ser_path = ser_en ? ser_aligned : '0;
  assign of_path  = offset_path_en ? of_word : '0;
  // modulo wrap is the intended phase behaviour
  assign sum_nxt  = cf_path + ser_path + of_path;

  // ***************************************************************
  // frequency sum and phase accumulator
  // ***************************************************************
  logic [FREQ_W-1:0] freq_sum_r;
  logic [FREQ_W-1:0] freq_sum_nxt;
  logic [FREQ_W-1:0] phase_r;
  logic [FREQ_W-1:0] phase_nxt;
  logic [FREQ_W-1:0] phase_fb;

  assign freq_sum_nxt = sum_nxt;
  // without feedback the accumulator just shows the current sum
  assign phase_fb     = fb_en ? phase_r : '0;
  assign phase_nxt    = phase_fb + freq_sum_r;

  // the sum is registered first so that the adder chain is split in
  // two stages; this costs one cycle of tuning latency
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      freq_sum_r <= '0;
      phase_r    <= '0;
    end
    else if (ce)
    begin
      freq_sum_r <= freq_sum_nxt;
      phase_r    <= phase_nxt;
    end
  end

  // ***************************************************************
  // registered outputs
  // ***************************************************************
  logic [2:0]        ser_len_r;
  logic              sync_early_r;
  logic              sync_low_r;
  logic              clk_fall_r;
  logic              lsb_first_r;
  logic [1:0]        timing_r;
  logic [FREQ_W-1:0] cf_out_r;
  logic              commit_r;

  // outputs trail the active registers by one cycle; reset values
  // match the active registers' reset values
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ser_len_r    <= dnc_pkg::RST_SER[dnc_pkg::SER_LEN_HI:dnc_pkg::SER_LEN_LO];
      sync_early_r <= dnc_pkg::RST_SER[dnc_pkg::SER_SYNC_EARLY];
      sync_low_r   <= dnc_pkg::RST_SER[dnc_pkg::SER_SYNC_LOW];
      clk_fall_r   <= dnc_pkg::RST_SER[dnc_pkg::SER_CLK_FALL];
      lsb_first_r  <= dnc_pkg::RST_SER[dnc_pkg::SER_LSB_FIRST];
      timing_r     <= dnc_pkg::RST_TT[dnc_pkg::TT_TIM_HI:dnc_pkg::TT_TIM_LO];
      cf_out_r     <= {dnc_pkg::RST_CF5, 40'h00_0000_0000};
      commit_r     <= 1'b0;
    end
    else if (ce)
    begin
      ser_len_r    <= len_code;
      sync_early_r <= ser_ctl[dnc_pkg::SER_SYNC_EARLY];
      sync_low_r   <= ser_ctl[dnc_pkg::SER_SYNC_LOW];
      clk_fall_r   <= ser_ctl[dnc_pkg::SER_CLK_FALL];
      lsb_first_r  <= ser_ctl[dnc_pkg::SER_LSB_FIRST];
      // any code is passed through; only 11b and 00b are meaningful
      timing_r     <= tt_ctl[dnc_pkg::TT_TIM_HI:dnc_pkg::TT_TIM_LO];
      cf_out_r     <= cf_word;
      commit_r     <= commit_now;
    end
  end

  assign ser_len_code     = ser_len_r;
  assign ser_sync_early   = sync_early_r;
  assign ser_sync_act_low = sync_low_r;
  assign ser_clk_fall     = clk_fall_r;
  assign ser_lsb_first    = lsb_first_r;
  assign dac_timing_sel   = timing_r;
  assign centre_freq_word = cf_out_r;
  assign freq_sum         = freq_sum_r;
  assign phase_acc        = phase_r;
  assign commit_seen      = commit_r;

endmodule : dnc_ctrl

// ===== tb/dnc_ctrl_asserts.sv
// port checker for the oscillator control bank
// assumes ce may drop at any time; frozen cycles are excused
`timescale 1ns/1ps
module dnc_ctrl_asserts
#(
  parameter int FREQ_W = 48,
  parameter int SER_W  = 40
)
(
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              ce,
  input wire logic              wr_strobe,
  input wire logic              wr_en_n,
  input wire logic [3:0]        addr,
  input wire logic              commit_n,
  input wire logic [SER_W-1:0]  ser_word,
  input wire logic              offset_path_en,
  input wire logic [2:0]        ser_len_code,
  input wire logic              ser_lsb_first,
  input wire logic [1:0]        dac_timing_sel,
  input wire logic [FREQ_W-1:0] centre_freq_word,
  input wire logic [FREQ_W-1:0] freq_sum,
  input wire logic [FREQ_W-1:0] phase_acc,
  input wire logic              commit_seen
);
  // *****
  // commit decode seen from the pins
  // *****
  logic wr_take;
  logic commit_c;
  assign wr_take  = ce & wr_strobe & ~wr_en_n;
  assign commit_c = ce & (~commit_n | (wr_take & (addr == 4'hf)));
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_quiet;
    !commit_c;
  endsequence
  sequence s_steady;
    $stable(ser_word) && $stable(offset_path_en);
  endsequence
  a_reset_vals: assert property (
    $fell(rst) |-> centre_freq_word == 48'h4000_0000_0000 &&
    dac_timing_sel == 2'b01 && !ser_lsb_first && ser_len_code == 3'h0 &&
    phase_acc == '0 && !commit_seen) else $error("bad reset values");
  a_pin_commit: assert property (
    ce && !commit_n |=> commit_seen) else $error("pin commit lost");
  a_addr15_commit: assert property (
    wr_take && addr == 4'hf |=> commit_seen) else $error("addr 15 no commit");
  a_seen_quiet: assert property (
    ce && s_quiet |=> !commit_seen) else $error("commit seen without cause");
  a_fields_hold: assert property (
    s_quiet |-> ##2 ($stable(centre_freq_word) && $stable(ser_len_code) &&
    $stable(ser_lsb_first) && $stable(dac_timing_sel)))
    else $error("active field moved without commit");
  a_sum_hold: assert property (
    s_quiet ##1 s_steady |=> $stable(freq_sum)) else $error("sum moved");
  a_acc_step: assert property (
    $past(ce) |-> phase_acc == $past(phase_acc) + $past(freq_sum) ||
    phase_acc == $past(freq_sum)) else $error("accumulator step wrong");
  a_timing_legal: assert property (
    dac_timing_sel != 2'b10) else $error("illegal timing code");
endmodule : dnc_ctrl_asserts

bind dnc_ctrl dnc_ctrl_asserts #(.FREQ_W(FREQ_W), .SER_W(SER_W)) i_chk
(.clk, .rst, .ce, .wr_strobe, .wr_en_n, .addr, .commit_n, .ser_word,
 .offset_path_en, .ser_len_code, .ser_lsb_first, .dac_timing_sel,
 .centre_freq_word, .freq_sum, .phase_acc, .commit_seen);

// ===== tb/dnc_host.sv
// host processor model on the write-only parallel port
// assumes the caller waits out reset before the first write
`timescale 1ns/1ps
module dnc_host
(
  input  wire logic clk,
  output logic      wr_strobe,
  output logic      wr_en_n,
  output logic [3:0] addr,
  output logic [7:0] wdata,
  output logic      commit_n
);
  // idle port at time zero
  initial
  begin
    wr_strobe = 1'b0;
    wr_en_n   = 1'b1;
    addr      = 4'h0;
    wdata     = 8'h00;
    commit_n  = 1'b1;
  end
  // one write cycle; idle lines show inverted junk, not the old value
  task automatic put(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == dnc_pkg::OFS_OSC)
      v = {1'b1, d[6:5], dnc_pkg::OSC_RSVD_LO_RST};
    if (a == dnc_pkg::OFS_TT)
      v = d[4] ? 8'h30 : 8'h00;
    @(negedge clk);
    wr_strobe = 1'b1;
    wr_en_n   = 1'b0;
    addr      = a;
    wdata     = v;
    @(negedge clk);
    wr_strobe = 1'b0;
    wr_en_n   = 1'b1;
    addr      = ~a;
    wdata     = ~v;
  endtask : put
  // one cycle of the commit pin
  task automatic update();
    @(negedge clk);
    commit_n = 1'b0;
    @(negedge clk);
    commit_n = 1'b1;
  endtask : update
endmodule : dnc_host

// ===== tb/testbench.sv
// self-checking bench for the oscillator control bank
// assumes the host model and the bound checker compile alongside
`timescale 1ns/1ps
module testbench;
  logic        clk, rst, ce, offset_path_en, wr_strobe, wr_en_n, commit_n;
  logic        ser_lsb_first, commit_seen;
  logic        ser_sync_early, ser_sync_act_low, ser_clk_fall;
  logic [3:0]  addr;
  logic [7:0]  wdata;
  logic [39:0] ser_word;
  logic [2:0]  ser_len_code;
  logic [1:0]  dac_timing_sel;
  logic [47:0] centre_freq_word, freq_sum, phase_acc, p;
  int          mismatches, num_checks, cycles;
  localparam logic [47:0] CF_RST = 48'h4000_0000_0000;
  dnc_host i_host (.clk, .wr_strobe, .wr_en_n, .addr, .wdata, .commit_n);
  dnc_ctrl i_dut (.clk, .rst, .ce, .wr_strobe, .wr_en_n, .addr, .wdata,
    .commit_n, .ser_word, .offset_path_en, .ser_len_code,
    .ser_sync_early, .ser_sync_act_low, .ser_clk_fall,
    .ser_lsb_first, .dac_timing_sel, .centre_freq_word, .freq_sum,
    .phase_acc, .commit_seen);
  // *****
  // helpers
  // *****
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // hang guard, far above the roughly 140 cycles needed
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test
  task automatic check(input string nm, input logic [47:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask : check
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_n
  // serial word placed under the top of the centre weighting
  function automatic logic [47:0] spath(input logic [2:0] c);
    if (c[2]) return {ser_word, 8'h00};
    case (c[1:0])
      2'd3:    return {ser_word[31:0], 16'h0000};
      2'd2:    return {ser_word[23:0], 24'h00_0000};
      2'd1:    return {ser_word[15:0], 32'h0000_0000};
      default: return {ser_word[7:0], 40'h00_0000_0000};
    endcase
  endfunction : spath
  task automatic set(input logic [3:0] a, input logic [7:0] d);
    i_host.put(a, d);
    i_host.update();
    wait_n(2);
  endtask : set
  // *****
  // scenarios
  // *****
  task automatic t_reset();
    check("centre", CF_RST, centre_freq_word);
    check("lsb", 48'h0, ser_lsb_first);
    check("timing", 48'h1, dac_timing_sel);
    check("len", 48'h0, ser_len_code);
    check("sum", CF_RST, freq_sum);
  endtask : t_reset
  task automatic t_timing();
    i_host.put(dnc_pkg::OFS_TT, 8'h30);
    wait_n(2);
    check("timing held", 48'h1, dac_timing_sel);
    i_host.put(dnc_pkg::OFS_COMMIT, 8'h5a);
    wait_n(2);
    check("timing 11", 48'h3, dac_timing_sel);
    set(dnc_pkg::OFS_TT, 8'h00);
    check("timing 00", 48'h0, dac_timing_sel);
  endtask : t_timing
  task automatic t_lengths();
    logic [2:0] codes [6] = '{3'd0, 3'd1, 3'd2, 3'd3, 3'd4, 3'd7};
    ser_word = 40'h9a_bcde_f123;
    foreach (codes[i])
    begin
      set(dnc_pkg::OFS_SER, {codes[i], 5'b0_0001});
      check("len", 48'(codes[i]), ser_len_code);
      check("sum", CF_RST + spath(codes[i]), freq_sum);
    end
    set(dnc_pkg::OFS_SER, 8'h03);
    check("lsb", 48'h1, ser_lsb_first);
    set(dnc_pkg::OFS_SER, 8'h1d);
    check("sync early", 48'h1, ser_sync_early);
    check("sync low", 48'h1, ser_sync_act_low);
    check("clk fall", 48'h1, ser_clk_fall);
    check("msb first", 48'h0, ser_lsb_first);
    set(dnc_pkg::OFS_SER, 8'h00);
    check("cf off", spath(3'd0), freq_sum);
    check("cf kept", CF_RST, centre_freq_word);
    set(dnc_pkg::OFS_SER, 8'h01);
  endtask : t_lengths
  task automatic t_osc();
    set(dnc_pkg::OFS_OSC, 8'hb8);
    check("ser off", CF_RST, freq_sum);
    set(dnc_pkg::OFS_OSC, 8'hd8);
    wait_n(1);
    check("no feedback", CF_RST + spath(3'd0), phase_acc);
    check("ser on", CF_RST + spath(3'd0), freq_sum);
    set(dnc_pkg::OFS_OSC, 8'hf8);
    p = phase_acc;
    wait_n(1);
    check("accumulate", p + CF_RST + spath(3'd0), phase_acc);
  endtask : t_osc
  task automatic t_holding();
    i_host.put(4'h5, 8'h80);
    i_host.put(4'h0, 8'h01);
    wait_n(2);
    check("hold hidden", CF_RST, centre_freq_word);
    i_host.update();
    check("seen", 48'h1, commit_seen);
    wait_n(2);
    check("committed", 48'h8000_0000_0001, centre_freq_word);
    check("seen gone", 48'h0, commit_seen);
    // offset word top byte, then open the offset path
    i_host.put(4'hb, 8'h01);
    i_host.update();
    offset_path_en = 1'b1;
    wait_n(2);
    check("offset sum", 48'h8100_0000_0001 + spath(3'd0), freq_sum);
  endtask : t_holding
  // clock enable low must freeze state and drop host cycles
  task automatic t_ce();
    ce = 1'b0;
    p = phase_acc;
    i_host.put(4'h0, 8'h55);
    i_host.update();
    check("ce freeze", p, phase_acc);
    ce = 1'b1;
    wait_n(2);
    check("ce write lost", 48'h8000_0000_0001, centre_freq_word);
  endtask : t_ce
  // main sequence
  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    offset_path_en = 1'b0;
    ser_word = 40'h00_0000_0000;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    wait_n(2);
    t_reset();
    t_timing();
    t_lengths();
    t_osc();
    t_holding();
    t_ce();
    stop_test();
  end
endmodule : testbench
